// ### dv/eepw_host.sv
// Two-wire bus controller model driving clock and data lines
`timescale 1ns/100ps
module eepw_host (
    // Clock
    input  wire logic clock,
    // Bus lines
    input  wire logic line,
    output logic      scl,
    output logic      sda
);
    // Bus idles high through the pull-up
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Half an SCL period, 64 ns
    task automatic half();
        repeat (8) @(posedge clock);
    endtask
    task automatic start();
        sda <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda <= 1'b0;
        half();
        scl <= 1'b0;
    endtask
    // data moves only with clock low
    // Sixteen clocks a bit, 128 ns, nearest the link period on this clock
    task automatic clk_bit(input logic b, output logic seen);
        repeat (2) @(posedge clock);
        sda <= b;
        repeat (6) @(posedge clock);
        scl <= 1'b1;
        half();
        seen = line;
        scl <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
        clk_bit(1'b1, s);
        ack = !s;
    endtask
    // read byte, then ack or nack
    task automatic rd(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(nack, s);
    endtask
    task automatic stop();
        repeat (2) @(posedge clock);
        sda <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda <= 1'b1;
        half();
    endtask
endmodule // eepw_host

// ### dv/eepw_props.sv
// Checker of bus timing and standby behaviour of the EEPROM target
`timescale 1ns/100ps
module eepw_props #(
    parameter int WRITE_CYCLE_COUNT = 300
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Bus pins
    input wire logic scl_pin,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    // Straps, protection, status
    input wire logic device_select_strap_low,
    input wire logic device_select_strap_high,
    input wire logic write_protect,
    input wire logic standby
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Idle bus out of standby means a write cycle; 16 clocks masks stop latency
    int   idle_q;
    int   idle_d;
    logic cyc_q;
    logic cyc_d;
    always_comb begin
        idle_d = (!standby && scl_pin && sda_in) ? idle_q + 1 : 0;
        cyc_d  = standby ? 1'b0 : (cyc_q || idle_q > 16);
    end
    always_ff @(posedge clock) begin
        idle_q <= rst ? 0 : idle_d;
        cyc_q  <= rst ? 1'b0 : cyc_d;
    end

    reset_vals_a: assert property ($fell(rst) |-> sda_oe_n && standby)
        else $error("outputs not at reset values");
    drain_zero_a: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    fall_on_low_a: assert property ($fell(sda_oe_n) |-> !scl_pin && !$past(scl_pin, 3))
        else $error("data driven outside clock low");
    ack_hold_a: assert property ($fell(sda_oe_n) |-> (!sda_oe_n) [*8])
        else $error("driven bit dropped early");
    drive_busy_a: assert property (!sda_oe_n |-> !standby)
        else $error("driving while in standby");
    start_cause_a: assert property ($fell(standby) |-> scl_pin && !sda_in)
        else $error("standby left without start");
    cycle_len_a: assert property (idle_q <= WRITE_CYCLE_COUNT + 16)
        else $error("write cycle too long");
    cycle_quiet_a: assert property (cyc_q |-> sda_oe_n)
        else $error("answer during write cycle");

    cover property ($fell(sda_oe_n));
    cover property ($rose(cyc_q));
    cover property (cyc_q ##1 standby);
endmodule // eepw_props

// ### dv/tb_eepw_top.sv
// Testbench of the two-wire EEPROM target
`timescale 1ns/100ps
module tb_eepw_top;
    import eepw_pkg::*;
    localparam int WCC = 300;
    logic       clock    = 1'b0;
    logic       rst      = 1'b1;
    logic       strap_lo = 1'b1;
    logic       strap_hi = 1'b0;
    logic       wp       = 1'b0;
    logic       scl, hsda, sda_out, sda_oe_n, standby, ack;
    logic [7:0] d;
    int         failures = 0;
    int         compares = 0;
    wire        sda_line = hsda & (sda_oe_n | sda_out);

    always #4 clock = ~clock;

    eepw_top #(.WRITE_CYCLE_COUNT(WCC)) dut_u (
        .clock(clock), .rst(rst), .scl_pin(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .device_select_strap_low(strap_lo),
        .device_select_strap_high(strap_hi), .write_protect(wp), .standby(standby));
    eepw_host host_u (.clock(clock), .line(sda_line), .scl(scl), .sda(hsda));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] dw(input logic p, input logic r);
        return {DEV_CODE, strap_hi, strap_lo, p, r};
    endfunction
    // Device word and both address bytes
    task automatic aim(input logic [16:0] a);
        host_u.start();
        host_u.xfer(dw(a[16], 1'b0), ack);
        chk(8'(ack), 8'h1);
        host_u.xfer(a[15:8], ack);
        chk(8'(ack), 8'h1);
        host_u.xfer(a[7:0], ack);
        chk(8'(ack), 8'h1);
    endtask
    task automatic wr(input logic [16:0] a, input logic [15:0] b, input logic two);
        aim(a);
        host_u.xfer(b[15:8], ack);
        chk(8'(ack), 8'h1);
        if (two) begin
            host_u.xfer(b[7:0], ack);
            chk(8'(ack), 8'h1);
        end
        host_u.stop();
    endtask
    task automatic rd_at(input logic [16:0] a, input logic [7:0] exp);
        aim(a);
        host_u.start();
        host_u.xfer(dw(a[16], 1'b1), ack);
        chk(8'(ack), 8'h1);
        host_u.rd(1'b1, d);
        host_u.stop();
        chk(d, exp);
    endtask
    // Bounded wait for standby
    task automatic idle();
        for (int i = 0; i < 2 * WCC && standby !== 1'b1; i++) @(posedge clock);
        chk(8'(standby), 8'h1);
    endtask
    // Byte write, polled while busy, read back
    task automatic t_write();
        wr(17'h1_1234, 16'h5a00, 1'b0);
        // Short gap, so poll and its stop both end inside the write cycle
        repeat (20) @(posedge clock);
        host_u.start();
        host_u.xfer(dw(1'b1, 1'b0), ack);
        host_u.stop();
        chk(8'(ack), 8'h0);
        chk(8'(standby), 8'h0);
        idle();
        rd_at(17'h1_1234, 8'h5a);
    endtask
    // Foreign device words, then swapped straps
    task automatic t_nack();
        logic [7:0] bad [4] = '{8'hb4, 8'ha0, 8'ha8, 8'hac};
        foreach (bad[i]) begin
            host_u.start();
            host_u.xfer(bad[i], ack);
            host_u.stop();
            chk(8'(ack), 8'h0);
            idle();
        end
        strap_lo <= 1'b0;
        strap_hi <= 1'b1;
        rd_at(17'h1_1234, 8'h5a);
    endtask
    // Protected write acked, no cycle, data kept
    task automatic t_wp();
        wp <= 1'b1;
        wr(17'h1_1234, 16'ha500, 1'b0);
        repeat (20) @(posedge clock);
        chk(8'(standby), 8'h1);
        wp <= 1'b0;
        rd_at(17'h1_1234, 8'h5a);
    endtask
    // Protocol recovery, page wrap, then a read across the page end
    task automatic t_wrap();
        host_u.start();
        host_u.xfer(dw(1'b0, 1'b0), ack);
        host_u.start();
        for (int i = 0; i < 9; i++) host_u.clk_bit(1'b1, ack);
        host_u.start();
        host_u.stop();
        idle();
        wr(17'h0_0400, 16'h3300, 1'b0);
        idle();
        wr(17'h0_03ff, 16'h1122, 1'b1);
        idle();
        rd_at(17'h0_0300, 8'h22);
        rd_at(17'h0_03ff, 8'h11);
        // reads leave the page, unlike writes
        aim(17'h0_03ff);
        host_u.start();
        host_u.xfer(dw(1'b0, 1'b1), ack);
        chk(8'(ack), 8'h1);
        host_u.rd(1'b0, d);
        chk(d, 8'h11);
        host_u.rd(1'b1, d);
        host_u.stop();
        chk(d, 8'h33);
    endtask
    task automatic close_out();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        chk(8'(standby), 8'h1);
        chk(8'(sda_oe_n), 8'h1);
        t_write();
        t_nack();
        t_wp();
        t_wrap();
        close_out();
    end
    // Watchdog well beyond the expected run
    initial begin
        #600_000;
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end
endmodule // tb_eepw_top

bind eepw_top eepw_props #(.WRITE_CYCLE_COUNT(WRITE_CYCLE_COUNT)) props_u (
    .clock(clock), .rst(rst), .scl_pin(scl_pin), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .device_select_strap_low(device_select_strap_low),
    .device_select_strap_high(device_select_strap_high), .write_protect(write_protect),
    .standby(standby));

// ### src/eepw_array.sv
// Memory array, page latch and self-timed write cycle
`timescale 1ns/100ps
module eepw_array #(
    parameter int WRITE_CYCLES = eepw_pkg::WRITE_CYCLE_CYC
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Link to the protocol engine
    eepw_if.array     bus
);
    import eepw_pkg::*;

    logic [DATA_W-1:0]     mem    [0:(1 << ADDR_W)-1];
    logic [DATA_W-1:0]     pg_mem [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] vld_q, vld_d;
    logic [ADDR_W-PAGE_W-1:0] row_q, row_d;
    logic                  busy_q, busy_d;
    logic [PAGE_W:0]       walk_q, walk_d;
    logic [TIMER_W-1:0]    timer_q, timer_d;
    logic                  accept, mem_we;
    logic [DATA_W-1:0]     rd_q;

    assign bus.wr_ready = !busy_q;
    assign bus.busy     = busy_q;
    assign bus.rd_data  = rd_q;

    // ----------------------------------------------------------------
    // Page latch and write cycle sequencing
    // ----------------------------------------------------------------
    always_comb begin
        vld_d   = vld_q;
        row_d   = row_q;
        busy_d  = busy_q;
        walk_d  = walk_q;
        timer_d = timer_q;
        mem_we  = 1'b0;
        accept  = bus.wr_valid && !busy_q;
        if (accept) begin
            vld_d[bus.wr_addr[PAGE_W-1:0]] = 1'b1;
            row_d = bus.wr_addr[ADDR_W-1:PAGE_W];
        end
        if (bus.abort && !busy_q) begin
            vld_d = '0;
        end
        if (bus.commit && !busy_q) begin
            busy_d  = 1'b1;
            walk_d  = '0;
            timer_d = '0;
        end
        if (busy_q) begin
            timer_d = timer_q + 1'b1;
            // Walk the latch, one byte a cycle, well inside the cycle time
            if (!walk_q[PAGE_W]) begin
                mem_we = vld_q[walk_q[PAGE_W-1:0]];
                vld_d[walk_q[PAGE_W-1:0]] = 1'b0;
                walk_d = walk_q + 1'b1;
            end
            // busy for exactly the cycle time
            if (timer_q == TIMER_W'(WRITE_CYCLES - 1)) begin
                busy_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            vld_q   <= '0;
            row_q   <= '0;
            busy_q  <= 1'b0;
            walk_q  <= '0;
            timer_q <= '0;
        end else begin
            vld_q   <= vld_d;
            row_q   <= row_d;
            busy_q  <= busy_d;
            walk_q  <= walk_d;
            timer_q <= timer_d;
        end
    end

    // ----------------------------------------------------------------
    // Storage, never reset since it models nonvolatile cells
    // ----------------------------------------------------------------
    // 512 pages of 256 bytes
    always_ff @(posedge clock) begin
        if (accept) begin
            pg_mem[bus.wr_addr[PAGE_W-1:0]] <= bus.wr_data;
        end
        if (mem_we) begin
            mem[{row_q, walk_q[PAGE_W-1:0]}] <= pg_mem[walk_q[PAGE_W-1:0]];
        end
        rd_q <= mem[bus.rd_addr];
    end
endmodule // eepw_array

// ### src/eepw_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module eepw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
    logic             push, pop;

    // Extra pointer bit tells full from empty
    always_comb begin
        in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
        out_valid = (wr_q != rd_q);
        out_data  = mem[rd_q[AW-1:0]];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wr_d      = push ? wr_q + 1'b1 : wr_q;
        rd_d      = pop ? rd_q + 1'b1 : rd_q;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule // eepw_fifo

// ### src/eepw_if.sv
// Link between the protocol engine and the array with its write cycle
`timescale 1ns/100ps
interface eepw_if (
    input wire logic clock
);
    import eepw_pkg::*;
    logic                wr_valid;
    logic                wr_ready;
    logic [ADDR_W-1:0]   wr_addr;
    logic [DATA_W-1:0]   wr_data;
    logic                commit;
    logic                abort;
    logic                busy;
    logic [ADDR_W-1:0]   rd_addr;
    logic [DATA_W-1:0]   rd_data;

    modport core  (output wr_valid, wr_addr, wr_data, commit, abort, rd_addr,
                   input  wr_ready, busy, rd_data);
    modport array (input  wr_valid, wr_addr, wr_data, commit, abort, rd_addr,
                   output wr_ready, busy, rd_data);
endinterface // eepw_if

// ### src/eepw_pkg.sv
// Constants and types of the two-wire EEPROM target
package eepw_pkg;
    // ----------------------------------------------------------------
    // Clock and write cycle timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ              = 125_000_000;
    localparam int WRITE_CYCLE_TIME_MS = 5;
    // Longest time, so the count rounds down
    localparam int WRITE_CYCLE_CYC     = WRITE_CYCLE_TIME_MS * (CLK_HZ / 1000);
    localparam int TIMER_W             = 20;

    // ----------------------------------------------------------------
    // Array geometry and word format
    // ----------------------------------------------------------------
    localparam int ADDR_W     = 17;
    localparam int DATA_W     = 8;
    localparam int PAGE_W     = 8;
    localparam int PAGE_BYTES = 256;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W     = ADDR_W + DATA_W;
    localparam logic [3:0] BIT_CNT_LAST = 4'h8;

    // ----------------------------------------------------------------
    // Device address word fields
    // ----------------------------------------------------------------
    localparam logic [3:0] DEV_CODE         = 4'ha;
    localparam int         DEV_STRAP_HI_BIT = 3;
    localparam int         DEV_STRAP_LO_BIT = 2;
    localparam int         DEV_PAGE_BIT     = 1;
    localparam int         DEV_RW_BIT       = 0;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic SDA_OE_N_RST = 1'b1;
    localparam logic STANDBY_RST  = 1'b1;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX   = 5'h02,
        ST_ACK  = 5'h04,
        ST_TX   = 5'h08,
        ST_RACK = 5'h10
    } eepw_state_t;

    typedef enum logic [1:0] {
        W_DEV  = 2'h0,
        W_HI   = 2'h1,
        W_LO   = 2'h2,
        W_DATA = 2'h3
    } eepw_word_t;
endpackage

// ### src/eepw_top.sv
// Two-wire serial EEPROM target: protocol engine and top level
`timescale 1ns/100ps
module eepw_top
    import eepw_pkg::*;
#(
    parameter int WRITE_CYCLE_COUNT = eepw_pkg::WRITE_CYCLE_CYC
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Two-wire bus pins
    input  wire logic scl_pin,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_n,
    // Straps and protection
    input  wire logic device_select_strap_low,
    input  wire logic device_select_strap_high,
    input  wire logic write_protect,
    // Status
    output logic      standby
);
    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [4:0] pin_s1, pin_s2;
    logic       scl_d, sda_d;
    logic       scl_s, sda_s, strap_lo_s, strap_hi_s, wp_s;
    logic       scl_rise, scl_fall, start_ev, stop_ev;

    // Two flops per pin, only the second stage is used below
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_s1 <= 5'h03;
            pin_s2 <= 5'h03;
            scl_d  <= 1'b1;
            sda_d  <= 1'b1;
        end else begin
            pin_s1 <= {write_protect, device_select_strap_high,
                       device_select_strap_low, sda_in, scl_pin};
            pin_s2 <= pin_s1;
            scl_d  <= pin_s2[0];
            sda_d  <= pin_s2[1];
        end
    end

    assign scl_s      = pin_s2[0];
    assign sda_s      = pin_s2[1];
    assign strap_lo_s = pin_s2[2];
    assign strap_hi_s = pin_s2[3];
    assign wp_s       = pin_s2[4];
    // bus edges for sample and drive
    assign scl_rise   = scl_s && !scl_d;
    assign scl_fall   = !scl_s && scl_d;
    // SDA change with SCL high is a condition
    assign start_ev   = scl_s && scl_d && sda_d && !sda_s;
    assign stop_ev    = scl_s && scl_d && !sda_d && sda_s;

    // ----------------------------------------------------------------
    // Buffering and array
    // ----------------------------------------------------------------
    eepw_if bus (.clock(clock));

    logic              push, fifo_ready, commit, abort;
    logic [FIFO_W-1:0] push_data;

    eepw_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (push_data),
        .out_valid (bus.wr_valid),
        .out_ready (bus.wr_ready),
        .out_data  ({bus.wr_addr, bus.wr_data})
    );

    eepw_array #(
        .WRITE_CYCLES (WRITE_CYCLE_COUNT)
    ) u_array (
        .clock (clock),
        .rst   (rst),
        .bus   (bus.array)
    );

    // ----------------------------------------------------------------
    // Protocol engine
    // ----------------------------------------------------------------
    eepw_state_t       state_q, state_d;
    eepw_word_t        word_q, word_d;
    logic [3:0]        cnt_q, cnt_d;
    logic [7:0]        sh_q, sh_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic              rw_q, rw_d;
    logic              oe_n_q, oe_n_d;
    logic              host_ack_q, host_ack_d;
    logic              pend_q, pend_d;
    logic              standby_q, standby_d;
    logic              dev_match, give_ack;

    assign push_data   = {addr_q, sh_q};
    assign bus.commit  = commit;
    assign bus.abort   = abort;
    assign bus.rd_addr = addr_q;

    assign dev_match = (sh_q[7:4] == DEV_CODE)
                    && (sh_q[DEV_STRAP_HI_BIT] == strap_hi_s)
                    && (sh_q[DEV_STRAP_LO_BIT] == strap_lo_s)
                    && !bus.busy;

    // Next state of the engine
    always_comb begin
        state_d    = state_q;
        word_d     = word_q;
        cnt_d      = cnt_q;
        sh_d       = sh_q;
        addr_d     = addr_q;
        rw_d       = rw_q;
        oe_n_d     = oe_n_q;
        host_ack_d = host_ack_q;
        pend_d     = pend_q;
        push       = 1'b0;
        commit     = 1'b0;
        abort      = 1'b0;
        give_ack   = 1'b0;
        if (stop_ev) begin
            state_d = ST_IDLE;
            oe_n_d  = 1'b1;
            pend_d  = 1'b0;
            if (pend_q && wp_s) begin
                abort = 1'b1;
            end else if (pend_q) begin
                commit = 1'b1;
            end
        end else if (start_ev) begin
            state_d = ST_RX;
            word_d  = W_DEV;
            cnt_d   = '0;
            oe_n_d  = 1'b1;
            // Restart without stop discards a half written page
            abort   = pend_q;
            pend_d  = 1'b0;
        end else begin
            case (state_q)
                ST_RX: begin
                    if (scl_rise && cnt_q != BIT_CNT_LAST) begin
                        sh_d  = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + 1'b1;
                    end
                    // eight bits then decide the ninth
                    if (scl_fall && cnt_q == BIT_CNT_LAST) begin
                        case (word_q)
                            W_DEV: begin
                                if (dev_match) begin
                                    give_ack = 1'b1;
                                    rw_d     = sh_q[DEV_RW_BIT];
                                    word_d   = W_HI;
                                    if (!sh_q[DEV_RW_BIT]) begin
                                        addr_d[ADDR_W-1] = sh_q[DEV_PAGE_BIT];
                                    end
                                end else begin
                                    state_d = ST_IDLE;
                                end
                            end
                            W_HI: begin
                                give_ack      = 1'b1;
                                addr_d[15:8]  = sh_q;
                                word_d        = W_LO;
                            end
                            W_LO: begin
                                give_ack      = 1'b1;
                                addr_d[7:0]   = sh_q;
                                word_d        = W_DATA;
                            end
                            default: begin
                                if (fifo_ready) begin
                                    give_ack    = 1'b1;
                                    push        = 1'b1;
                                    pend_d      = 1'b1;
                                    addr_d[PAGE_W-1:0] = addr_q[PAGE_W-1:0] + 1'b1;
                                end else begin
                                    state_d = ST_IDLE;
                                end
                            end
                        endcase
                        if (give_ack) begin
                            // pull SDA low for the ninth clock
                            state_d = ST_ACK;
                            oe_n_d  = 1'b0;
                            cnt_d   = '0;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            // first read byte, bit 7 first
                            state_d = ST_TX;
                            sh_d    = bus.rd_data;
                            oe_n_d  = bus.rd_data[7];
                            cnt_d   = 4'h1;
                            addr_d  = addr_q + 1'b1;
                        end else begin
                            state_d = ST_RX;
                            oe_n_d  = 1'b1;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_q == BIT_CNT_LAST) begin
                            state_d = ST_RACK;
                            oe_n_d  = 1'b1;
                        end else begin
                            oe_n_d  = sh_q[6];
                            sh_d    = {sh_q[6:0], 1'b0};
                            cnt_d   = cnt_q + 1'b1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        host_ack_d = !sda_s;
                    end
                    if (scl_fall) begin
                        if (host_ack_q) begin
                            state_d = ST_TX;
                            sh_d    = bus.rd_data;
                            oe_n_d  = bus.rd_data[7];
                            cnt_d   = 4'h1;
                            addr_d  = addr_q + 1'b1;
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end
                end
                default: begin
                    oe_n_d = 1'b1;
                end
            endcase
        end
        // standby once idle, no write running or starting
        standby_d = (state_d == ST_IDLE) && !bus.busy && !commit;
    end

    // Register the engine
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q    <= ST_IDLE;
            word_q     <= W_DEV;
            cnt_q      <= '0;
            sh_q       <= '0;
            addr_q     <= '0;
            rw_q       <= 1'b0;
            oe_n_q     <= SDA_OE_N_RST;
            host_ack_q <= 1'b0;
            pend_q     <= 1'b0;
            standby_q  <= STANDBY_RST;
        end else begin
            state_q    <= state_d;
            word_q     <= word_d;
            cnt_q      <= cnt_d;
            sh_q       <= sh_d;
            addr_q     <= addr_d;
            rw_q       <= rw_d;
            oe_n_q     <= oe_n_d;
            host_ack_q <= host_ack_d;
            pend_q     <= pend_d;
            standby_q  <= standby_d;
        end
    end

    // Open drain: data is always low, only the enable moves
    always_ff @(posedge clock) begin
        sda_out <= 1'b0;
    end

    assign sda_oe_n = oe_n_q;
    assign standby  = standby_q;
endmodule // eepw_top
